/* ep0t_regs.svh */
// Constants for the endpoint-zero control and toggle-reset block
`ifndef EP0T_REGS_SVH
`define EP0T_REGS_SVH
`define EP0T_ADDR_BUF 6'h31
`define EP0T_ADDR_SETUP 6'h32
`define EP0T_ADDR_COUNT 6'h33
`define EP0T_ADDR_IND_LO 6'h3a
`define EP0T_ADDR_IND_HI 6'h3b
`define EP0T_ADDR_IND_DATA 6'h3c
`define EP0T_TOGGLE_ADDR 16'he683
`define EP0T_TOGGLE_SEL_RESET 5'h12
`define EP0T_CMD_SELECT 3'h4
`define EP0T_MAX_PKT 8'h40
`define EP0T_BIT_ADDR 7
`define EP0T_BIT_READ 6
`define EP0T_BIT_TOG_Q 7
`define EP0T_BIT_TOG_SET 6
`define EP0T_BIT_TOG_CLR 5
`define EP0T_REQ_CLEAR_FEATURE 8'h01
`define EP0T_REQ_SET_FEATURE 8'h03
`define EP0T_RCPT_ENDPOINT 5'h02
`define EP0T_TYPE_STANDARD 2'h0
`endif

/* ep0t_pkg.sv */
// Types for the endpoint-zero control and toggle-reset block
package ep0t_pkg;
    typedef enum logic [1:0] {
        ST_ADDR,
        ST_HI,
        ST_LO,
        ST_RDWAIT
    } ep0t_cmd_state_t;
endpackage

/* ep0t_top.sv */
// Endpoint-zero control logic, command decoder, toggle window and FIFOs
`timescale 1ns/1ps
`include "ep0t_regs.svh"

module ep0t_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic full_reg, full_next, empty_reg, empty_next;
    logic push, pop;

    assign push = in_valid && !full_reg;
    assign pop = !empty_reg && out_ready;
    assign in_ready = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data = mem[rd_ptr_reg];

    // Pointer and occupancy update, flags kept registered
    always_comb
    begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push)
            wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
        if (pop)
            rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
        if (push && !pop)
            count_next = count_reg + 1'b1;
        else if (pop && !push)
            count_next = count_reg - 1'b1;
        full_next = (count_next == DEPTH_C);
        empty_next = (count_next == '0);
    end

    // Registers
    always_ff @(posedge clk)
    begin
        wr_ptr_reg <= reset ? '0 : wr_ptr_next;
        rd_ptr_reg <= reset ? '0 : rd_ptr_next;
        count_reg <= reset ? '0 : count_next;
        full_reg <= reset ? 1'b0 : full_next;
        empty_reg <= reset ? 1'b1 : empty_next;
    end

    // Storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end
endmodule

module ep0t_top
    import ep0t_pkg::*;
#(
    parameter int IN_DEPTH = 32,
    parameter int OUT_DEPTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command interface towards the external master
    input wire logic cmd_strobe,
    input wire logic [2:0] interface_address_select,
    input wire logic [7:0] low_data_lines_in,
    output logic [7:0] low_data_lines_out,
    output logic low_data_lines_oe,
    input wire logic data_taken,
    output logic ready,
    output logic int_n,
    // Setup packets from the serial engine
    input wire logic setup_valid,
    input wire logic [63:0] setup_packet,
    // IN data towards the serial engine
    output logic in_valid,
    output logic [7:0] in_data,
    input wire logic in_ready,
    output logic in_commit,
    output logic [7:0] in_commit_len,
    // OUT data from the serial engine
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    output logic out_ready,
    // Handshake control
    output logic status_ack,
    output logic ep0_stall,
    // Data toggles
    input wire logic toggle_flip,
    input wire logic [4:0] toggle_flip_sel,
    output logic [31:0] toggles
);
    ep0t_cmd_state_t state_reg, state_next;
    logic [5:0] cmd_addr_reg, cmd_addr_next;
    logic [3:0] hi_nib_reg, hi_nib_next;
    logic ready_reg, ready_next, int_n_reg, int_n_next;
    logic [7:0] dout_reg, dout_next;
    logic doe_reg, doe_next;
    logic [63:0] setup_reg, setup_next;
    logic [2:0] setup_idx_reg, setup_idx_next;
    logic setup_pend_reg, setup_pend_next, buf_pend_reg, buf_pend_next;
    logic stall_reg, stall_next, active_reg, active_next;
    logic dir_in_reg, dir_in_next, in_wait_reg, in_wait_next;
    logic [15:0] remaining_reg, remaining_next;
    logic [15:0] out_total_reg, out_total_next;
    logic [7:0] pkt_cnt_reg, pkt_cnt_next, out_count_reg, out_count_next;
    logic commit_reg, commit_next, ack_reg, ack_next;
    logic [7:0] commit_len_reg, commit_len_next;
    logic [15:0] ind_addr_reg, ind_addr_next;
    logic [4:0] tog_sel_reg, tog_sel_next;
    logic [31:0] tog_reg, tog_next;
    logic take, in_push, in_fifo_ready, in_fifo_valid, out_pop;
    logic out_fifo_valid, out_fifo_in_ready, out_acc, auto_req;
    logic [7:0] out_fifo_data, wbyte, clen, rdata;
    logic [15:0] wlen;

    // IN packet staging between buffer-port writes and the serial engine
    ep0t_fifo #(.WIDTH(8), .DEPTH(IN_DEPTH)) u_in_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(in_push),
        .in_data(wbyte),
        .in_ready(in_fifo_ready),
        .out_valid(in_fifo_valid),
        .out_data(in_data),
        .out_ready(in_ready)
    );

    // OUT packet holding until the master reads it out
    ep0t_fifo #(.WIDTH(8), .DEPTH(OUT_DEPTH)) u_out_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(out_valid),
        .in_data(out_data),
        .in_ready(out_fifo_in_ready),
        .out_valid(out_fifo_valid),
        .out_data(out_fifo_data),
        .out_ready(out_pop)
    );

    // Command byte accepted only on the command select while ready
    assign take = cmd_strobe && ready_reg &&
        (interface_address_select == `EP0T_CMD_SELECT);
    assign wbyte = {hi_nib_reg, low_data_lines_in[3:0]};
    assign in_push = take && (state_reg == ST_LO) &&
        !low_data_lines_in[`EP0T_BIT_ADDR] &&
        (cmd_addr_reg == `EP0T_ADDR_BUF);
    assign out_pop = take && (state_reg != ST_RDWAIT) &&
        (low_data_lines_in[7:6] == 2'b11) &&
        (low_data_lines_in[5:0] == `EP0T_ADDR_BUF);
    assign out_acc = out_valid && out_fifo_in_ready;
    assign wlen = {setup_packet[63:56], setup_packet[55:48]};
    // Standard requests are automatic except endpoint set/clear feature
    assign auto_req = (setup_packet[6:5] == `EP0T_TYPE_STANDARD) &&
        !((setup_packet[4:0] == `EP0T_RCPT_ENDPOINT) &&
          ((setup_packet[15:8] == `EP0T_REQ_SET_FEATURE) ||
           (setup_packet[15:8] == `EP0T_REQ_CLEAR_FEATURE)));
    // Byte count write clamped to the remaining requested length
    assign clen = (remaining_reg < {8'h00, wbyte}) ?
        remaining_reg[7:0] : wbyte;

    // Read data mux for the command read request
    always_comb
    begin
        rdata = 8'h00;
        case (low_data_lines_in[5:0])
            `EP0T_ADDR_BUF: rdata = out_fifo_data;
            `EP0T_ADDR_SETUP: rdata = setup_reg[{setup_idx_reg, 3'b000} +: 8];
            `EP0T_ADDR_COUNT: rdata = out_count_reg;
            `EP0T_ADDR_IND_DATA:
                if (ind_addr_reg == `EP0T_TOGGLE_ADDR)
                    rdata = {tog_reg[tog_sel_reg], 2'b00, tog_sel_reg};
            default: rdata = 8'h00;
        endcase
    end

    // Command decoder, endpoint-zero sequencing and toggle window
    always_comb
    begin
        state_next = state_reg;
        cmd_addr_next = cmd_addr_reg;
        hi_nib_next = hi_nib_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        setup_next = setup_reg;
        setup_idx_next = setup_idx_reg;
        setup_pend_next = setup_pend_reg;
        buf_pend_next = buf_pend_reg;
        stall_next = stall_reg;
        active_next = active_reg;
        dir_in_next = dir_in_reg;
        in_wait_next = in_wait_reg;
        remaining_next = remaining_reg;
        out_total_next = out_total_reg;
        pkt_cnt_next = pkt_cnt_reg;
        out_count_next = out_count_reg;
        commit_next = 1'b0;
        commit_len_next = commit_len_reg;
        ack_next = 1'b0;
        ind_addr_next = ind_addr_reg;
        tog_sel_next = tog_sel_reg;
        tog_next = tog_reg;
        if (toggle_flip)
            tog_next[toggle_flip_sel] = !tog_reg[toggle_flip_sel];
        // Command bytes
        if (take && state_reg != ST_RDWAIT)
        begin
            if (low_data_lines_in[`EP0T_BIT_ADDR])
            begin
                // Address byte restarts any partial write
                cmd_addr_next = low_data_lines_in[5:0];
                state_next = ST_HI;
                if (low_data_lines_in[`EP0T_BIT_READ])
                begin
                    state_next = ST_RDWAIT;
                    dout_next = rdata;
                    doe_next = 1'b1;
                    if (low_data_lines_in[5:0] == `EP0T_ADDR_SETUP)
                    begin
                        setup_idx_next = setup_idx_reg + 1'b1;
                        setup_pend_next = 1'b0;
                    end
                    if (low_data_lines_in[5:0] == `EP0T_ADDR_COUNT ||
                        low_data_lines_in[5:0] == `EP0T_ADDR_BUF)
                        buf_pend_next = 1'b0;
                end
            end
            else if (state_reg == ST_HI)
            begin
                hi_nib_next = low_data_lines_in[3:0];
                state_next = ST_LO;
            end
            else if (state_reg == ST_LO)
            begin
                state_next = ST_HI; // series of bytes to the same address
                case (cmd_addr_reg)
                    `EP0T_ADDR_BUF: buf_pend_next = 1'b0;
                    `EP0T_ADDR_SETUP:
                        if (wbyte != 8'h00)
                            stall_next = 1'b1;
                    `EP0T_ADDR_COUNT:
                    begin
                        buf_pend_next = 1'b0;
                        // Only the byte count register sends short packets
                        if (dir_in_reg || remaining_reg == 16'h0000)
                        begin
                            commit_next = 1'b1;
                            commit_len_next = clen;
                            remaining_next = remaining_reg - {8'h00, clen};
                            in_wait_next = 1'b1;
                            if (clen < `EP0T_MAX_PKT ||
                                remaining_reg == {8'h00, clen})
                            begin
                                ack_next = 1'b1;
                                active_next = 1'b0;
                                in_wait_next = 1'b0;
                            end
                        end
                    end
                    `EP0T_ADDR_IND_LO: ind_addr_next[7:0] = wbyte;
                    `EP0T_ADDR_IND_HI: ind_addr_next[15:8] = wbyte;
                    `EP0T_ADDR_IND_DATA:
                        if (ind_addr_reg == `EP0T_TOGGLE_ADDR)
                        begin
                            tog_sel_next = wbyte[4:0];
                            if (wbyte[`EP0T_BIT_TOG_SET])
                                tog_next[wbyte[4:0]] = 1'b1;
                            else if (wbyte[`EP0T_BIT_TOG_CLR])
                                tog_next[wbyte[4:0]] = 1'b0;
                        end
                    default: ;
                endcase
            end
        end
        // Read data stays driven until the master has taken it
        if (state_reg == ST_RDWAIT && data_taken)
        begin
            state_next = ST_ADDR;
            doe_next = 1'b0;
        end
        // IN buffer drained: writable again while the transfer continues
        if (in_wait_reg && !in_fifo_valid && !commit_reg)
        begin
            in_wait_next = 1'b0;
            if (active_reg)
                buf_pend_next = 1'b1;
        end
        // OUT bytes from the host
        if (out_acc)
        begin
            pkt_cnt_next = pkt_cnt_reg + 1'b1;
            out_total_next = out_total_reg + 1'b1;
            if (out_last)
            begin
                out_count_next = pkt_cnt_reg + 1'b1;
                pkt_cnt_next = 8'h00;
                buf_pend_next = 1'b1;
            end
            if (active_reg && !dir_in_reg &&
                out_total_reg + 1'b1 >= remaining_reg)
            begin
                ack_next = 1'b1;
                active_next = 1'b0;
            end
        end
        // New setup packet, overriding any transfer in progress
        if (setup_valid)
        begin
            setup_next = setup_packet;
            setup_idx_next = 3'h0;
            stall_next = 1'b0;
            remaining_next = wlen;
            dir_in_next = setup_packet[7];
            out_total_next = 16'h0000;
            pkt_cnt_next = 8'h00;
            in_wait_next = 1'b0;
            active_next = !auto_req;
            if (!auto_req || active_reg)
                setup_pend_next = 1'b1;
            if (!auto_req && setup_packet[7] && wlen != 16'h0000)
                buf_pend_next = 1'b1;
        end
    end

    // Ready pacing and interrupt pin
    always_comb
    begin
        // Low for the cycle after each byte, while reading, or buffer full
        ready_next = !take && (state_next != ST_RDWAIT) &&
            in_fifo_ready;
        // Read data owns the pin; pending events wait behind it
        int_n_next = !((state_next == ST_RDWAIT) ||
            setup_pend_next || buf_pend_next);
    end

    // Registers
    always_ff @(posedge clk)
    begin
        state_reg <= reset ? ST_ADDR : state_next;
        cmd_addr_reg <= reset ? 6'h00 : cmd_addr_next;
        hi_nib_reg <= reset ? 4'h0 : hi_nib_next;
        ready_reg <= reset ? 1'b0 : ready_next;
        int_n_reg <= reset ? 1'b1 : int_n_next;
        dout_reg <= reset ? 8'h00 : dout_next;
        doe_reg <= reset ? 1'b0 : doe_next;
        setup_reg <= reset ? 64'h0 : setup_next;
        setup_idx_reg <= reset ? 3'h0 : setup_idx_next;
        setup_pend_reg <= reset ? 1'b0 : setup_pend_next;
        buf_pend_reg <= reset ? 1'b0 : buf_pend_next;
        stall_reg <= reset ? 1'b0 : stall_next;
        active_reg <= reset ? 1'b0 : active_next;
        dir_in_reg <= reset ? 1'b0 : dir_in_next;
        in_wait_reg <= reset ? 1'b0 : in_wait_next;
        remaining_reg <= reset ? 16'h0000 : remaining_next;
        out_total_reg <= reset ? 16'h0000 : out_total_next;
        pkt_cnt_reg <= reset ? 8'h00 : pkt_cnt_next;
        out_count_reg <= reset ? 8'h00 : out_count_next;
        commit_reg <= reset ? 1'b0 : commit_next;
        commit_len_reg <= reset ? 8'h00 : commit_len_next;
        ack_reg <= reset ? 1'b0 : ack_next;
        ind_addr_reg <= reset ? 16'h0000 : ind_addr_next;
        tog_sel_reg <= reset ? `EP0T_TOGGLE_SEL_RESET : tog_sel_next;
        tog_reg <= reset ? 32'h0 : tog_next;
    end

    // Outputs
    assign ready = ready_reg;
    assign int_n = int_n_reg;
    assign low_data_lines_out = dout_reg;
    assign low_data_lines_oe = doe_reg;
    assign in_valid = in_fifo_valid;
    assign out_ready = out_fifo_in_ready;
    assign in_commit = commit_reg;
    assign in_commit_len = commit_len_reg;
    assign status_ack = ack_reg;
    assign ep0_stall = stall_reg;
    assign toggles = tog_reg;
endmodule

/* ep0t_top_props.sv */
// Concurrent checks on the endpoint-zero block's ports
`timescale 1ns/1ps
module ep0t_top_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command bus
    input wire logic cmd_strobe,
    input wire logic [2:0] interface_address_select,
    input wire logic [7:0] low_data_lines_in,
    input wire logic low_data_lines_oe,
    input wire logic data_taken,
    input wire logic ready,
    input wire logic int_n,
    // Control transfer side
    input wire logic setup_valid,
    input wire logic [63:0] setup_packet,
    input wire logic in_commit,
    input wire logic ep0_stall
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // A command byte counts only with select 100 and ready high
    wire logic take = cmd_strobe && ready && interface_address_select == 3'h4;
    wire logic feat = setup_packet[6:0] == 7'h02 &&
        (setup_packet[15:8] == 8'h01 || setup_packet[15:8] == 8'h03);
    a_ready_drop: assert property (take |=> !ready)
        else $error("ready stayed high after a taken byte");
    a_read_data: assert property (take && low_data_lines_in[7:6] == 2'b11
        |=> low_data_lines_oe && !int_n) else $error("read data not shown");
    a_read_hold: assert property (low_data_lines_oe && !data_taken
        |=> low_data_lines_oe) else $error("read data dropped early");
    a_read_end: assert property (low_data_lines_oe && data_taken
        |=> !low_data_lines_oe) else $error("read data held too long");
    a_read_busy: assert property (low_data_lines_oe |-> !ready && !int_n)
        else $error("ready or int wrong in read wait");
    a_feat_int: assert property (setup_valid && feat |=> !int_n)
        else $error("endpoint feature request raised no event");
    a_stall_hold: assert property (ep0_stall && !setup_valid |=> ep0_stall)
        else $error("stall released without setup");
    a_stall_clear: assert property (setup_valid |=> !ep0_stall)
        else $error("stall kept across setup");
    a_commit_once: assert property (in_commit |=> !in_commit)
        else $error("commit longer than one cycle");
endmodule
bind ep0t_top ep0t_top_props u_props (.clk(clk), .reset(reset),
    .cmd_strobe(cmd_strobe), .interface_address_select(interface_address_select),
    .low_data_lines_in(low_data_lines_in), .low_data_lines_oe(low_data_lines_oe),
    .data_taken(data_taken), .ready(ready), .int_n(int_n),
    .setup_valid(setup_valid), .setup_packet(setup_packet),
    .in_commit(in_commit), .ep0_stall(ep0_stall));

/* ep0t_master_model.sv */
// External master model speaking the nibble command protocol
`timescale 1ns/1ps
module ep0t_master_model (
    // From the block
    input wire logic clk,
    input wire logic ready,
    input wire logic low_data_lines_oe,
    input wire logic [7:0] low_data_lines_out,
    // To the block
    output logic cmd_strobe = 1'b0,
    output logic [2:0] interface_address_select = 3'h4,
    output logic [7:0] low_data_lines_in = 8'h00,
    output logic data_taken = 1'b0
);
    int hangs = 0;
    // One byte, started once ready is seen high or after 200 cycles of waiting
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        hangs += (n >= 200);
        cmd_strobe = 1'b1;
        low_data_lines_in = b;
        @(posedge clk);
        #1;
        cmd_strobe = 1'b0;
        low_data_lines_in = ~b;
    endtask
    // Address byte, then high and low nibbles
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        put({2'b10, a});
        put({4'h0, v[7:4]});
        put({4'h0, v[3:0]});
    endtask
    // Read address byte, wait for data, then release it
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        int n;
        n = 0;
        put({2'b11, a});
        while (low_data_lines_oe !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        hangs += (n >= 200);
        v = low_data_lines_out;
        data_taken = 1'b1;
        @(posedge clk);
        #1;
        data_taken = 1'b0;
    endtask
    // Indirect window: address low, high, then data
    task automatic ind_wr(input logic [7:0] v);
        wr(6'h3a, 8'h83);
        wr(6'h3b, 8'he6);
        wr(6'h3c, v);
    endtask
    task automatic ind_rd(output logic [7:0] v);
        wr(6'h3a, 8'h83);
        wr(6'h3b, 8'he6);
        rd(6'h3c, v);
    endtask
endmodule

/* test_ep0t_top.sv */
// Self-checking bench for the endpoint-zero control and toggle block
`timescale 1ns/1ps
module test_ep0t_top;
    logic clk, reset, cmd_strobe, low_data_lines_oe, data_taken, ready;
    logic int_n, setup_valid, in_valid, in_commit, out_valid, in_go;
    logic out_last, out_ready, status_ack, ep0_stall, toggle_flip;
    logic in_ready = 1'b0;
    logic [2:0] interface_address_select;
    logic [7:0] low_data_lines_in, low_data_lines_out, in_data, v;
    logic [7:0] in_commit_len, out_data;
    logic [4:0] toggle_flip_sel, s;
    logic [31:0] toggles, tv;
    logic [63:0] setup_packet;
    integer seed = 32'h505dd86d;
    int n_mismatch, checks_done, n_ack, last_len, i, k;
    int eps[5] = '{0, 1, 2, 6, 8};
    logic [7:0] q_in[$], q_out[$];
    ep0t_top u_dut (.clk(clk), .reset(reset), .cmd_strobe(cmd_strobe),
        .interface_address_select(interface_address_select),
        .low_data_lines_in(low_data_lines_in), .ready(ready), .int_n(int_n),
        .low_data_lines_out(low_data_lines_out), .data_taken(data_taken),
        .low_data_lines_oe(low_data_lines_oe), .setup_valid(setup_valid),
        .setup_packet(setup_packet), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .in_commit(in_commit), .out_valid(out_valid),
        .in_commit_len(in_commit_len), .out_data(out_data), .out_last(out_last),
        .out_ready(out_ready), .status_ack(status_ack), .ep0_stall(ep0_stall),
        .toggle_flip(toggle_flip), .toggle_flip_sel(toggle_flip_sel),
        .toggles(toggles));
    ep0t_master_model u_host (.clk(clk), .ready(ready),
        .low_data_lines_oe(low_data_lines_oe), .data_taken(data_taken),
        .low_data_lines_out(low_data_lines_out), .cmd_strobe(cmd_strobe),
        .interface_address_select(interface_address_select),
        .low_data_lines_in(low_data_lines_in));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Serial-engine side: stalls pops at random, logs handshakes
    always @(posedge clk)
    begin
        #1;
        in_ready = in_go && ($random(seed) & 1);
    end
    always @(posedge clk)
    begin
        if (status_ack === 1'b1)
            n_ack <= n_ack + 1;
        if (in_commit === 1'b1)
            last_len <= in_commit_len;
        if (in_valid === 1'b1 && in_ready === 1'b1)
            q_out.push_back(in_data);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        n_mismatch += u_host.hangs;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Setup packet with random value and index, then read it back
    task automatic setup(input logic [7:0] rt, input logic [7:0] rq,
        input logic [15:0] len);
        setup_packet = {len, $random(seed), rq, rt};
        setup_valid = 1'b1;
        @(posedge clk);
        #1;
        setup_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(ep0_stall, 1'b0);
        check(int_n, 1'b0);
        for (k = 0; k < 8; k++)
        begin
            u_host.rd(6'h32, v);
            check(v, setup_packet[k * 8 +: 8]);
        end
    endtask
    // One byte into the endpoint-zero buffer
    task automatic load_byte;
        v = 8'($random(seed));
        q_in.push_back(v);
        u_host.wr(6'h31, v);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial
    begin
        {setup_valid, out_valid, out_last, toggle_flip, in_go} = '0;
        {setup_packet, out_data, toggle_flip_sel, tv, n_ack} = '0;
        reset = 1'b1;
        settle(16);
        reset = 1'b0;
        u_host.ind_rd(v);
        check(v, 8'h12);
        u_host.rd(6'h3d, v);
        check(v, 8'h00);
        for (i = 0; i < 10; i++)
        begin
            s = {i[0], 4'(eps[i / 2])};
            u_host.ind_wr({3'b000, s});
            u_host.ind_wr({3'b010, s});
            tv[s] = 1'b1;
            u_host.ind_rd(v);
            check(v, {tv[s], 2'b00, s});
            u_host.ind_wr({3'b001, s});
            tv[s] = 1'b0;
            toggle_flip_sel = s;
            toggle_flip = 1'b1;
            tv[s] = ~tv[s];
            settle(1);
            toggle_flip = 1'b0;
            u_host.ind_rd(v);
            check(v, {tv[s], 2'b00, s});
            check(toggles, tv);
        end
        $display("toggle window test done");
        setup(8'h02, 8'h01, 16'h0000);
        k = n_ack;
        u_host.wr(6'h33, 8'h00);
        settle(2);
        check(n_ack - k, 1);
        $display("no-data setup test done");
        setup(8'h02, 8'h03, 16'h0000);
        u_host.wr(6'h32, 8'h00);
        check(ep0_stall, 1'b0);
        u_host.interface_address_select = 3'h0;
        u_host.wr(6'h32, 8'hff);
        u_host.interface_address_select = 3'h4;
        check(ep0_stall, 1'b0);
        v = 8'($random(seed)) | 8'h01;
        u_host.wr(6'h32, v);
        settle(2);
        check(ep0_stall, 1'b1);
        $display("stall test done");
        setup(8'hc0, 8'h55, 16'd100);
        for (i = 0; i < 32; i++)
            load_byte();
        settle(8);
        check(ready, 1'b0);
        in_go = 1'b1;
        for (i = 0; i < 32; i++)
            load_byte();
        k = n_ack;
        u_host.wr(6'h33, 8'd64);
        settle(2);
        check(last_len, 64);
        check(n_ack - k, 0);
        for (i = 0; i < 36; i++)
            load_byte();
        u_host.wr(6'h33, 8'd40);
        settle(2);
        check(last_len, 36);
        check(n_ack - k, 1);
        for (k = 0; k < 2000 && q_out.size() < 100; k++)
            settle(1);
        check(q_out.size(), 100);
        while (q_in.size() > 0 && q_out.size() > 0)
            check(q_out.pop_front(), q_in.pop_front());
        q_in.delete();
        $display("in data phase test done");
        setup(8'h40, 8'h66, 16'd10);
        k = n_ack;
        for (i = 0; i < 10; i++)
        begin
            {out_valid, out_data, out_last} = {1'b1, 8'($random(seed)), i == 9};
            q_in.push_back(out_data);
            settle(1);
        end
        {out_valid, out_last} = 2'b00;
        settle(2);
        check(n_ack - k, 1);
        check(int_n, 1'b0);
        check(out_ready, 1'b1);
        u_host.rd(6'h33, v);
        check(v, 8'd10);
        for (i = 0; i < 10; i++)
        begin
            u_host.rd(6'h31, v);
            check(v, q_in.pop_front());
        end
        $display("out data phase test done");
        end_sim();
    end
    initial
    begin
        #400000;
        n_mismatch++;
        end_sim();
    end
endmodule
